// File: rtl/osel_defines.svh
// constants of the optical channel selector control
`ifndef OSEL_DEFINES_SVH
`define OSEL_DEFINES_SVH
`define OSEL_CLK_HZ 20000000
`define OSEL_SETTLE_MS 500
`define OSEL_SETTLE_CYC ((`OSEL_CLK_HZ / 1000) * `OSEL_SETTLE_MS)
`define OSEL_INIT_MS 1000
`define OSEL_INIT_CYC ((`OSEL_CLK_HZ / 1000) * `OSEL_INIT_MS)
`define OSEL_FLASH_HZ 2
`define OSEL_FLASH_CYC (`OSEL_CLK_HZ / `OSEL_FLASH_HZ)
`define OSEL_ADDR_CMD 4'h0
`define OSEL_ADDR_CHAN 4'h1
`define OSEL_ADDR_STAT 4'h2
`define OSEL_ADDR_IRQ 4'h3
`define OSEL_ADDR_MASK 4'h4
`define OSEL_CMD_CLOSE 2'h1
`define OSEL_CMD_OPEN 2'h2
`define OSEL_CMD_OPENALL 2'h3
`define OSEL_EV_DONE 0
`define OSEL_EV_MULTI 1
`define OSEL_EV_FAULT 2
`define OSEL_NEV 3
`endif

// File: rtl/osel_pkg.sv
// types of the optical channel selector control
`default_nettype none
package osel_pkg;
  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } state_t;
  typedef struct packed {
    logic [1:0] op;
    logic [15:0] chans;
  } cmd_t;
endpackage
`default_nettype wire

// File: rtl/osel_divider.sv
// divider giving a toggling level while run is high, held cleared otherwise
`timescale 1ns/1ns
`default_nettype none
module osel_divider #(
  parameter int unsigned HALF = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  output logic wave
);
  logic [31:0] cnt_reg;
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_reg <= 32'h0;
      wave <= 1'b0;
    end else if (cnt_reg >= 32'(HALF - 1)) begin
      cnt_reg <= 32'h0;
      wave <= ~wave;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule // osel_divider
`default_nettype wire

// File: rtl/optical_channel_selector_ctrl.sv
// optical channel selector control with avalon register slave
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "osel_defines.svh"
module optical_channel_selector_ctrl #(
  parameter int unsigned NCHAN = 16,
  parameter int unsigned SETTLE_CYC = `OSEL_SETTLE_CYC,
  parameter int unsigned INIT_CYC = `OSEL_INIT_CYC,
  parameter int unsigned FLASH_HALF = `OSEL_FLASH_CYC / 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  // switch module
  input wire logic moduleFault,
  output logic [NCHAN-1:0] chanSelect,
  output logic chanValid,
  output logic busy,
  // lamp and interrupt
  output logic errLamp,
  output logic irq
);
  osel_pkg::state_t state_reg;
  osel_pkg::cmd_t cmd;
  logic [31:0] timer_reg;
  logic multiErr_reg;
  logic [2:0] irqStat_reg;
  logic [2:0] irqMask_reg;
  logic faultMeta_reg;
  logic fault_reg;
  logic fault_d_reg;
  logic flashWave;
  logic cmdWrite;
  logic oneHot;
  logic settleDone;
  logic [2:0] events;

  assign cmd.op = avWriteData[17:16];
  assign cmd.chans = avWriteData[15:0];
  // accept commands only while idle; writes are taken as one-cycle answers
  assign cmdWrite = avWrite && !avWaitRequest && avAddress == `OSEL_ADDR_CMD
                    && state_reg == osel_pkg::ST_IDLE && cmd.op != 2'h0;
  assign oneHot = cmd.chans != 16'h0 && (cmd.chans & (cmd.chans - 16'h1)) == 16'h0;
  assign settleDone = state_reg == osel_pkg::ST_BUSY && timer_reg == 32'h0;

  // fault pin synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      faultMeta_reg <= 1'b0;
      fault_reg <= 1'b0;
      fault_d_reg <= 1'b0;
    end else begin
      faultMeta_reg <= moduleFault;
      fault_reg <= faultMeta_reg;
      fault_d_reg <= fault_reg;
    end
  end

  // switch state machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= osel_pkg::ST_INIT;
      timer_reg <= 32'h0;
      chanSelect <= '0;
    end else begin
      case (state_reg)
        osel_pkg::ST_INIT: begin
          chanSelect <= '0;
          if (timer_reg >= 32'(INIT_CYC - 1)) begin
            timer_reg <= 32'h0;
            state_reg <= osel_pkg::ST_IDLE;
          end else begin
            timer_reg <= timer_reg + 32'h1;
          end
        end
        osel_pkg::ST_IDLE: begin
          if (cmdWrite && cmd.op != 2'h0) begin
            timer_reg <= 32'(SETTLE_CYC - 1);
            state_reg <= osel_pkg::ST_BUSY;
            case (cmd.op)
              `OSEL_CMD_CLOSE: chanSelect <= oneHot ? cmd.chans[NCHAN-1:0] : '0;
              `OSEL_CMD_OPEN: begin
                if ((cmd.chans[NCHAN-1:0] & chanSelect) != '0) begin
                  chanSelect <= '0;
                end
              end
              `OSEL_CMD_OPENALL: chanSelect <= '0;
              default: chanSelect <= chanSelect;
            endcase
          end
        end
        osel_pkg::ST_BUSY: begin
          if (timer_reg == 32'h0) begin
            state_reg <= osel_pkg::ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        default: state_reg <= osel_pkg::ST_INIT;
      endcase
    end
  end

  // busy and valid flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b1;
      chanValid <= 1'b0;
    end else begin
      busy <= state_reg != osel_pkg::ST_IDLE || cmdWrite;
      chanValid <= state_reg == osel_pkg::ST_IDLE && !cmdWrite && chanSelect != '0;
    end
  end

  // multi-close error: a non one-hot close sets it, any valid command clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      multiErr_reg <= 1'b0;
    end else if (cmdWrite && cmd.op == `OSEL_CMD_CLOSE && !oneHot) begin
      multiErr_reg <= 1'b1;
    end else if (cmdWrite && cmd.op != 2'h0) begin
      multiErr_reg <= 1'b0;
    end
  end

  osel_divider #(
    .HALF(FLASH_HALF)
  ) flashDiv (
    .mclk(mclk),
    .rst(rst),
    .run(multiErr_reg),
    .wave(flashWave)
  );

  // lamp: steady on fault, flashing on multi-close error
  always_ff @(posedge mclk) begin
    if (rst) begin
      errLamp <= 1'b0;
    end else begin
      errLamp <= fault_reg || (multiErr_reg && !flashWave);
    end
  end

  // sticky interrupt status, set wins over write-one clear
  assign events[`OSEL_EV_DONE] = settleDone;
  assign events[`OSEL_EV_MULTI] = cmdWrite && cmd.op == `OSEL_CMD_CLOSE && !oneHot;
  assign events[`OSEL_EV_FAULT] = fault_reg && !fault_d_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqStat_reg <= 3'h0;
      irqMask_reg <= 3'h0;
    end else begin
      if (avWrite && !avWaitRequest && avAddress == `OSEL_ADDR_IRQ) begin
        irqStat_reg <= (irqStat_reg & ~avWriteData[2:0]) | events;
      end else begin
        irqStat_reg <= irqStat_reg | events;
      end
      if (avWrite && !avWaitRequest && avAddress == `OSEL_ADDR_MASK) begin
        irqMask_reg <= avWriteData[2:0];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (irqStat_reg & irqMask_reg) != 3'h0;
    end
  end

  // bus slave: one wait cycle per access
  always_ff @(posedge mclk) begin
    if (rst) begin
      avWaitRequest <= 1'b1;
    end else begin
      avWaitRequest <= !((avRead || avWrite) && avWaitRequest);
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      avReadData <= 32'h0;
    end else if (avRead && avWaitRequest) begin
      case (avAddress)
        `OSEL_ADDR_CHAN: avReadData <= 32'(chanSelect);
        `OSEL_ADDR_STAT: avReadData <= {27'h0, fault_reg, multiErr_reg, chanValid,
                                         busy, state_reg == osel_pkg::ST_INIT};
        `OSEL_ADDR_IRQ: avReadData <= {29'h0, irqStat_reg};
        `OSEL_ADDR_MASK: avReadData <= {29'h0, irqMask_reg};
        default: avReadData <= 32'h0;
      endcase
    end
  end

  // helper: cycles since the lamp last changed while it should flash
  logic lampPrev_reg;
  logic [31:0] lampAge_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      lampPrev_reg <= 1'b0;
      lampAge_reg <= 32'h0;
    end else begin
      lampPrev_reg <= errLamp;
      if (errLamp != lampPrev_reg || !multiErr_reg || fault_reg) begin
        lampAge_reg <= 32'h0;
      end else begin
        lampAge_reg <= lampAge_reg + 32'h1;
      end
    end
  end

  // checks on the switch, the lamp and the bus
  a_lamp_flash: assert property (@(posedge mclk) disable iff (rst)
    lampAge_reg <= 32'(FLASH_HALF))
    else $error("lamp stopped flashing");
  a_init_blocked: assert property (@(posedge mclk) disable iff (rst)
    state_reg == osel_pkg::ST_INIT |-> chanSelect == '0 && busy)
    else $error("switch not reset during init");
  a_multi_clear: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite && !(cmd.op == `OSEL_CMD_CLOSE && !oneHot) |=> !multiErr_reg)
    else $error("valid command left error set");
  a_open_other: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite && cmd.op == `OSEL_CMD_OPEN && (cmd.chans[NCHAN-1:0] & chanSelect) == '0
    |=> $stable(chanSelect))
    else $error("open of idle channel changed connection");
  a_one_conn: assert property (@(posedge mclk) disable iff (rst)
    (chanSelect & (chanSelect - NCHAN'(1))) == '0)
    else $error("more than one channel connected");
  a_busy_cmd: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite |=> busy && !chanValid)
    else $error("connection valid while switching");
  a_done_sticky: assert property (@(posedge mclk) disable iff (rst)
    settleDone |=> irqStat_reg[`OSEL_EV_DONE])
    else $error("settle done not recorded");
  a_fault_irq: assert property (@(posedge mclk) disable iff (rst)
    events[`OSEL_EV_FAULT] |=> irqStat_reg[`OSEL_EV_FAULT])
    else $error("fault event not recorded");
  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    (irqStat_reg & irqMask_reg) != 3'h0 |=> irq)
    else $error("interrupt not raised");
  a_answer_next: assert property (@(posedge mclk) disable iff (rst)
    (avRead || avWrite) && avWaitRequest |=> !avWaitRequest)
    else $error("bus request not answered");
  a_wait_once: assert property (@(posedge mclk) disable iff (rst)
    !avWaitRequest |=> avWaitRequest)
    else $error("wait request low twice");
  a_close_connects: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite && cmd.op == `OSEL_CMD_CLOSE && oneHot |=> chanSelect == $past(cmd.chans[NCHAN-1:0]))
    else $error("close did not connect channel");
  a_multi_resets: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite && cmd.op == `OSEL_CMD_CLOSE && !oneHot |=> chanSelect == '0 && multiErr_reg)
    else $error("multi close did not reset");
  a_openall_reset: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite && cmd.op == `OSEL_CMD_OPENALL |=> chanSelect == '0 && !multiErr_reg)
    else $error("open all did not reset");
  a_open_blocks: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite && cmd.op == `OSEL_CMD_OPEN && (cmd.chans[NCHAN-1:0] & chanSelect) != '0
    |=> chanSelect == '0)
    else $error("open left channel connected");
  a_hold_conn: assert property (@(posedge mclk) disable iff (rst)
    !cmdWrite && state_reg != osel_pkg::ST_INIT |=> $stable(chanSelect))
    else $error("connection changed without command");
  a_busy_valid: assert property (@(posedge mclk) disable iff (rst)
    busy |-> !chanValid)
    else $error("valid while busy");
  a_settle_len: assert property (@(posedge mclk) disable iff (rst)
    cmdWrite |=> state_reg == osel_pkg::ST_BUSY && timer_reg == 32'(SETTLE_CYC - 1))
    else $error("settle timer wrong");
  a_fault_lamp: assert property (@(posedge mclk) disable iff (rst)
    fault_reg |=> errLamp)
    else $error("fault lamp not steady");
  a_lamp_off: assert property (@(posedge mclk) disable iff (rst)
    !fault_reg && !multiErr_reg |=> !errLamp)
    else $error("lamp lit without cause");
  c_close: cover property (@(posedge mclk) cmdWrite && cmd.op == `OSEL_CMD_CLOSE && oneHot);
  c_multi: cover property (@(posedge mclk) multiErr_reg && errLamp);
  c_valid: cover property (@(posedge mclk) chanValid);
  c_fault: cover property (@(posedge mclk) fault_reg && errLamp);
  c_open: cover property (@(posedge mclk) cmdWrite && cmd.op == `OSEL_CMD_OPEN);
endmodule // optical_channel_selector_ctrl
`default_nettype wire

// File: bench/mainframe_model.sv
// mainframe-side model issuing channel commands over avalon-mm
`timescale 1ns/1ns
`default_nettype none
module mainframe_model (
  // clock
  input wire logic mclk,
  // avalon-mm master
  input wire logic [31:0] avReadData,
  input wire logic avWaitRequest,
  output logic [3:0] avAddress,
  output logic avRead,
  output logic avWrite,
  output logic [31:0] avWriteData
);
  initial begin
    avAddress = 4'h0;
    avRead = 1'b0;
    avWrite = 1'b0;
    avWriteData = 32'h0;
  end
  // hold request until waitrequest sampled low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    avAddress <= a;
    avWrite <= w;
    avRead <= !w;
    avWriteData <= d;
    @(posedge mclk);
    while (avWaitRequest !== 1'b0) @(posedge mclk);
    q = avReadData;
    avWrite <= 1'b0;
    avRead <= 1'b0;
  endtask
  // one write to the command register: op in bits 17:16, channel mask in bits 15:0
  task automatic cmd(input logic [1:0] op, input logic [15:0] ch);
    logic [31:0] q;
    xfer(1'b1, 4'h0, {14'h0, op, ch}, q);
  endtask
  // poll status until the card has finished switching
  task automatic wait_idle;
    logic [31:0] q;
    do begin
      xfer(1'b0, 4'h2, 32'h0, q);
    end while (q[1] !== 1'b0);
  endtask
  // simple scan: reset, single-channel steps, one close per list entry
  task automatic scan(input logic [15:0] list [4], output logic [15:0] seen [4]);
    logic [31:0] q;
    cmd(2'h3, 16'h0);
    wait_idle();
    foreach (list[i]) begin
      if (i > 0) begin
        cmd(2'h2, list[i-1]);
        wait_idle();
      end
      cmd(2'h1, list[i]);
      wait_idle();
      xfer(1'b0, 4'h1, 32'h0, q);
      seen[i] = q[15:0];
    end
  endtask
endmodule // mainframe_model
`default_nettype wire

// File: bench/tb_optical_channel_selector_ctrl.sv
// testbench of the optical channel selector control
`timescale 1ns/1ns
`default_nettype none
module tb_optical_channel_selector_ctrl;
  logic mclk, rst, moduleFault, avRead, avWrite, avWaitRequest, chanValid, busy, errLamp, irq;
  logic prev;
  logic [3:0] avAddress;
  logic [31:0] avWriteData, avReadData, q;
  logic [15:0] chanSelect;
  logic [15:0] scanList [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008};
  logic [15:0] seen [4];
  int errors = 0;
  int comparisons = 0;
  int n;
  mainframe_model mf (.mclk(mclk), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData));
  optical_channel_selector_ctrl #(.NCHAN(16), .SETTLE_CYC(8), .INIT_CYC(4), .FLASH_HALF(3)) uut (
    .mclk(mclk), .rst(rst), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWriteData(avWriteData), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .moduleFault(moduleFault), .chanSelect(chanSelect), .chanValid(chanValid), .busy(busy),
    .errLamp(errLamp), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // poll status until not busy
  task automatic settle;
    n = 0;
    do begin
      mf.xfer(1'b0, 4'h2, 32'h0, q);
      n++;
    end while (q[1] !== 1'b0 && n < 40);
    chk("busy", 32'h0, {31'h0, q[1]});
    chk("busy pin", 32'h0, {31'h0, busy});
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    moduleFault = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    settle();
    chk("reset chan", 32'h0, {16'h0, chanSelect});
    mf.cmd(2'h1, 16'h0020);
    @(posedge mclk);
    chk("valid early", 32'h0, {31'h0, chanValid});
    chk("busy early", 32'h1, {31'h0, busy});
    settle();
    chk("close", 32'h20, {16'h0, chanSelect});
    chk("valid", 32'h1, {31'h0, chanValid});
    mf.cmd(2'h2, 16'h0020);
    settle();
    chk("open", 32'h0, {16'h0, chanSelect});
    mf.cmd(2'h1, 16'h0004);
    settle();
    mf.cmd(2'h1, 16'h0003);
    settle();
    chk("multi", 32'h0, {16'h0, chanSelect});
    mf.xfer(1'b0, 4'h2, 32'h0, q);
    chk("multi flag", 32'h1, {31'h0, q[3]});
    n = 0;
    prev = errLamp;
    repeat (12) begin
      @(posedge mclk);
      if (errLamp !== prev) n++;
      prev = errLamp;
    end
    chk("flash", 32'h1, {31'h0, n >= 3 && n <= 5});
    mf.cmd(2'h3, 16'h0);
    settle();
    chk("openall", 32'h0, {16'h0, chanSelect});
    chk("lamp off", 32'h0, {31'h0, errLamp});
    mf.xfer(1'b0, 4'h3, 32'h0, q);
    chk("irq status", 32'h3, q);
    mf.scan(scanList, seen);
    foreach (seen[i]) begin
      chk("scan step", {16'h0, scanList[i]}, {16'h0, seen[i]});
    end
    mf.xfer(1'b1, 4'h4, 32'h4, q);
    mf.xfer(1'b1, 4'h3, 32'h7, q);
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge mclk);
    moduleFault <= 1'b1;
    repeat (6) @(posedge mclk);
    repeat (8) begin
      @(posedge mclk);
      chk("lamp steady", 32'h1, {31'h0, errLamp});
    end
    chk("irq", 32'h1, {31'h0, irq});
    mf.xfer(1'b0, 4'h3, 32'h0, q);
    chk("fault event", 32'h1, {31'h0, q[2]});
    mf.xfer(1'b1, 4'h3, 32'h4, q);
    repeat (2) @(posedge mclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    mf.xfer(1'b0, 4'hf, 32'h0, q);
    chk("unmapped", 32'h0, q);
    end_of_test();
  end
endmodule // tb_optical_channel_selector_ctrl
`default_nettype wire
